/* File: hdl/gdr_release_timer.v */
`timescale 1ns/1ps
`include "gdr_regs.vh"
module gdr_release_timer #(
	parameter W = 32
) (
	input wire clk,
	input wire rst,
	input wire arm,
	input wire [W-1:0] delay,
	output reg done
);
	reg [W-1:0] count;
	always @(posedge clk) begin
		if (rst || !arm) begin
			count <= {W{1'b0}}; // see [R22]
			done <= 1'b0;
		end else if (count >= delay) begin
			done <= 1'b1; // see [R2]
		end else begin
			count <= count + {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule

/* File: hdl/gdr_stage.v */
`timescale 1ns/1ps
`include "gdr_regs.vh"
module gdr_stage #(
	parameter W = 32
) (
	input wire clk,
	input wire rst,
	input wire run,
	input wire over,
	input wire [1:0] mode,
	input wire [1:0] dir,
	input wire dir_ok,
	input wire [W-1:0] delay,
	output reg pickup,
	output reg expired
);
	reg [W-1:0] count;
	reg match;
	always @* begin
		case (mode)
		`GDR_MODE_FWD: match = dir_ok && dir == `GDR_DIR_FWD; // see [R18]
		`GDR_MODE_REV: match = dir_ok && dir == `GDR_DIR_REV; // see [R18]
		default: match = 1'b1;
		endcase
	end
	always @(posedge clk) begin
		if (rst || !(run && over && match)) begin
			count <= {W{1'b0}};
			pickup <= 1'b0;
			expired <= 1'b0;
		end else begin
			// In directional modes own delay counts only after release, so the two add
			pickup <= 1'b1; // see [R3]
			if (count >= delay)
				expired <= 1'b1;
			else
				count <= count + {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule

/* File: hdl/gdr_top.v */
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`include "gdr_regs.vh"
module gdr_top #(
	parameter NSIG = 16,
	parameter NMOD = 4,
	parameter VW = 16
) (
	input wire CLOCK,
	input wire SYS_RST,
	input wire [3:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	output reg [31:0] AVS_READDATA,
	output reg AVS_WAITREQUEST,
	input wire [VW-1:0] NEUTRAL_VOLTAGE_MEAS,
	input wire [VW-1:0] PHASE_VOLTAGE_A,
	input wire [VW-1:0] PHASE_VOLTAGE_B,
	input wire [VW-1:0] PHASE_VOLTAGE_C,
	input wire [VW-1:0] MEAS_ACTIVE_CURRENT,
	input wire [VW-1:0] MEAS_REACTIVE_CURRENT,
	input wire [VW-1:0] CALC_ACTIVE_CURRENT,
	input wire [VW-1:0] CALC_REACTIVE_CURRENT,
	input wire [VW-1:0] MEAS_CURRENT_ANGLE,
	input wire [VW-1:0] CALC_CURRENT_ANGLE,
	input wire [NSIG-1:0] ASSIGNABLE_SIGNALS,
	input wire [NMOD-1:0] REVERSE_INTERLOCK,
	input wire [NMOD-1:0] MODULE_OVER,
	output reg DIRECTION_RELEASED,
	output reg [1:0] DIRECTION,
	output reg [NMOD-1:0] MODULE_ACTIVE,
	output reg [NMOD-1:0] MODULE_PICKUP,
	output reg [NMOD-1:0] TRIP_COMMAND,
	output reg GENERAL_ALARM,
	output reg GENERAL_TRIP
);
	reg [31:0] ctrl;
	reg [VW-1:0] neutral_voltage_threshold;
	reg [31:0] direction_release_delay;
	reg [VW-1:0] measured_residual_current_threshold;
	reg [VW-1:0] measured_limit_angle_one;
	reg [VW-1:0] measured_limit_angle_two;
	reg [VW-1:0] computed_residual_current_threshold;
	reg [VW-1:0] computed_limit_angle_one;
	reg [VW-1:0] computed_limit_angle_two;
	reg [VW-1:0] ground_transformer_angle_correction;
	reg [31:0] mod_cfg;
	reg [31:0] blk_sel;
	reg [31:0] stage_delay;
	wire [VW-1:0] next_mthr;
	wire [VW-1:0] mthr_min;
	reg [VW+1:0] volt_sum;
	reg [VW-1:0] neutral_voltage;
	reg [VW-1:0] oper_current;
	reg [VW-1:0] cur_thr;
	reg [VW-1:0] ang_one;
	reg [VW-1:0] ang_two;
	reg [VW:0] ang_sum;
	reg [VW-1:0] ang;
	reg [1:0] raw_dir;
	reg gate;
	wire released;
	wire global_run;
	wire [NMOD-1:0] pickup;
	wire [NMOD-1:0] expired;
	wire [NMOD-1:0] run;
	wire [NMOD-1:0] trip_ok;
	wire sel_g;
	wire sel_1;
	wire sel_2;
	wire sel_t;
	wire bus_read;
	wire bus_write;
	reg [31:0] next_rdata;
	assign bus_read = AVS_READ && AVS_WAITREQUEST;
	assign bus_write = AVS_WRITE && AVS_WAITREQUEST;
	// Minimum clamp depends on which card feeds the current input
	assign mthr_min = ctrl[`GDR_CTRL_SENS] ? `GDR_MTHR_SENS_MIN : `GDR_MTHR_STD_MIN;
	assign next_mthr = (AVS_WRITEDATA[VW-1:0] < mthr_min) ? mthr_min : // see [R5]
		(AVS_WRITEDATA[VW-1:0] > `GDR_MTHR_MAX) ? `GDR_MTHR_MAX : // see [R6]
		AVS_WRITEDATA[VW-1:0];
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			ctrl <= `GDR_CTRL_RESET;
			neutral_voltage_threshold <= {VW{1'b0}};
			direction_release_delay <= 32'h0000_0000;
			measured_residual_current_threshold <= `GDR_MTHR_STD_MIN;
			measured_limit_angle_one <= {VW{1'b0}};
			measured_limit_angle_two <= `GDR_ANG_FULL;
			computed_residual_current_threshold <= `GDR_MTHR_STD_MIN;
			computed_limit_angle_one <= {VW{1'b0}};
			computed_limit_angle_two <= `GDR_ANG_FULL;
			ground_transformer_angle_correction <= {VW{1'b0}};
			mod_cfg <= 32'h0000_0000;
			blk_sel <= 32'h0000_0000;
			stage_delay <= 32'h0000_0000;
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h0000_0000;
		end else begin
			// One wait cycle, then answer; bus idles with waitrequest high
			AVS_WAITREQUEST <= !(bus_read || bus_write);
			AVS_READDATA <= bus_read ? next_rdata : 32'h0000_0000;
			if (bus_write) begin
				case (AVS_ADDRESS)
				`GDR_ADDR_CTRL: ctrl <= AVS_WRITEDATA;
				`GDR_ADDR_VTHR: neutral_voltage_threshold <= AVS_WRITEDATA[VW-1:0];
				`GDR_ADDR_DLY: direction_release_delay <= AVS_WRITEDATA;
				`GDR_ADDR_MTHR: measured_residual_current_threshold <= next_mthr;
				`GDR_ADDR_MANG: begin
					measured_limit_angle_one <= AVS_WRITEDATA[VW-1:0];
					measured_limit_angle_two <= AVS_WRITEDATA[31:16];
				end
				`GDR_ADDR_CTHR: computed_residual_current_threshold <= next_mthr;
				`GDR_ADDR_CANG: begin
					computed_limit_angle_one <= AVS_WRITEDATA[VW-1:0];
					computed_limit_angle_two <= AVS_WRITEDATA[31:16];
				end
				`GDR_ADDR_ACOR: ground_transformer_angle_correction <= AVS_WRITEDATA[VW-1:0];
				`GDR_ADDR_MOD: mod_cfg <= AVS_WRITEDATA;
				`GDR_ADDR_BSEL: blk_sel <= AVS_WRITEDATA;
				`GDR_ADDR_SDLY: stage_delay <= AVS_WRITEDATA;
				default: ;
				endcase
			end
		end
	end
	always @* begin
		case (AVS_ADDRESS)
		`GDR_ADDR_CTRL: next_rdata = ctrl;
		`GDR_ADDR_VTHR: next_rdata = {16'h0000, neutral_voltage_threshold};
		`GDR_ADDR_DLY: next_rdata = direction_release_delay;
		`GDR_ADDR_MTHR: next_rdata = {16'h0000, measured_residual_current_threshold};
		`GDR_ADDR_MANG: next_rdata = {measured_limit_angle_two, measured_limit_angle_one};
		`GDR_ADDR_CTHR: next_rdata = {16'h0000, computed_residual_current_threshold};
		`GDR_ADDR_CANG: next_rdata = {computed_limit_angle_two, computed_limit_angle_one};
		`GDR_ADDR_ACOR: next_rdata = {16'h0000, ground_transformer_angle_correction};
		`GDR_ADDR_MOD: next_rdata = mod_cfg;
		`GDR_ADDR_BSEL: next_rdata = blk_sel;
		`GDR_ADDR_SDLY: next_rdata = stage_delay;
		`GDR_ADDR_STAT: next_rdata = {22'h00_0000, GENERAL_TRIP, GENERAL_ALARM,
			TRIP_COMMAND[3:0], DIRECTION, gate, DIRECTION_RELEASED};
		default: next_rdata = 32'h0000_0000;
		endcase
	end
	// Neutral voltage origin and direction evaluation
	always @* begin
		volt_sum = {2'b00, PHASE_VOLTAGE_A} + {2'b00, PHASE_VOLTAGE_B} +
			{2'b00, PHASE_VOLTAGE_C};
		neutral_voltage = ctrl[`GDR_CTRL_VORIG] ? // see [R21]
			((volt_sum[VW+1:VW] != 2'b00) ? {VW{1'b1}} : volt_sum[VW-1:0]) :
			NEUTRAL_VOLTAGE_MEAS;
		if (ctrl[`GDR_CTRL_CALC]) begin
			// see [R8]
			oper_current = ctrl[`GDR_CTRL_METH] ? CALC_REACTIVE_CURRENT : CALC_ACTIVE_CURRENT;
			cur_thr = computed_residual_current_threshold;
			ang_one = computed_limit_angle_one;
			ang_two = computed_limit_angle_two;
			ang_sum = {1'b0, CALC_CURRENT_ANGLE} + {1'b0, ground_transformer_angle_correction};
		end else begin
			// see [R4] [R20]
			oper_current = ctrl[`GDR_CTRL_METH] ? MEAS_REACTIVE_CURRENT : MEAS_ACTIVE_CURRENT;
			cur_thr = measured_residual_current_threshold;
			ang_one = measured_limit_angle_one;
			ang_two = measured_limit_angle_two;
			ang_sum = {1'b0, MEAS_CURRENT_ANGLE} + {1'b0, ground_transformer_angle_correction};
		end
		// Angle in degrees relative to neutral voltage, wrapped to 0..359
		ang = (ang_sum >= {1'b0, `GDR_ANG_FULL}) ?
			ang_sum[VW-1:0] - `GDR_ANG_FULL : ang_sum[VW-1:0]; // see [R9]
		if (oper_current > cur_thr && ang >= ang_one && ang <= ang_two) // see [R7]
			raw_dir = ang < 16'h00B4 ? `GDR_DIR_FWD : `GDR_DIR_REV;
		else
			raw_dir = `GDR_DIR_NONE;
		gate = neutral_voltage > neutral_voltage_threshold; // see [R1]
	end
	gdr_release_timer #(.W(32)) u_rel (
		.clk(CLOCK),
		.rst(SYS_RST),
		.arm(gate),
		.delay(direction_release_delay),
		.done(released)
	);
	// Blocking network; sources picked by index from the signal list
	assign sel_g = ASSIGNABLE_SIGNALS[blk_sel[3:0]]; // see [R16]
	assign sel_1 = ASSIGNABLE_SIGNALS[blk_sel[7:4]];
	assign sel_2 = ASSIGNABLE_SIGNALS[blk_sel[11:8]];
	assign sel_t = ASSIGNABLE_SIGNALS[blk_sel[15:12]];
	assign global_run = ctrl[`GDR_CTRL_GEN] && // see [R10]
		!(ctrl[`GDR_CTRL_GPERM] && sel_g); // see [R13]
	genvar i;
	generate
		for (i = 0; i < NMOD; i = i + 1) begin : g_mod
			// mod_cfg byte: 0 enable, 1 ext permit, 2 perm trip block,
			// 3 trip permit, 5:4 mode, 6 supervision, 7 phase module
			assign run[i] = global_run && mod_cfg[8*i] && // see [R11]
				!(mod_cfg[8*i+1] && (sel_1 || sel_2)) && // see [R14]
				!(mod_cfg[8*i+7] && REVERSE_INTERLOCK[i]); // see [R17]
			assign trip_ok[i] = !mod_cfg[8*i+2] && // see [R12]
				!(mod_cfg[8*i+3] && sel_t) && // see [R15]
				!mod_cfg[8*i+6]; // see [R19]
			gdr_stage #(.W(8)) u_stage (
				.clk(CLOCK),
				.rst(SYS_RST),
				.run(run[i]),
				.over(MODULE_OVER[i]),
				.mode(mod_cfg[8*i+5:8*i+4]),
				.dir(DIRECTION),
				.dir_ok(DIRECTION_RELEASED),
				.delay(stage_delay[8*i+7:8*i]),
				.pickup(pickup[i]),
				.expired(expired[i])
			);
		end
	endgenerate
	always @(posedge CLOCK) begin
		if (SYS_RST) begin
			DIRECTION_RELEASED <= 1'b0;
			DIRECTION <= `GDR_DIR_NONE;
			MODULE_ACTIVE <= {NMOD{1'b0}};
			MODULE_PICKUP <= {NMOD{1'b0}};
			TRIP_COMMAND <= {NMOD{1'b0}};
			GENERAL_ALARM <= 1'b0;
			GENERAL_TRIP <= 1'b0;
		end else begin
			DIRECTION_RELEASED <= released && gate; // see [R2] [R22]
			DIRECTION <= (released && gate) ? raw_dir : `GDR_DIR_NONE; // see [R1]
			MODULE_ACTIVE <= run;
			MODULE_PICKUP <= pickup;
			TRIP_COMMAND <= expired & trip_ok;
			GENERAL_ALARM <= |(pickup & ~mod_cfg_sup(mod_cfg)); // see [R19]
			GENERAL_TRIP <= |(expired & ~mod_cfg_sup(mod_cfg));
		end
	end
	function [NMOD-1:0] mod_cfg_sup;
		input [31:0] cfg;
		integer k;
		begin
			for (k = 0; k < NMOD; k = k + 1)
				mod_cfg_sup[k] = cfg[8*k+6];
		end
	endfunction
endmodule

/* File: include/gdr_regs.vh */
// How it works
// [R1] Withhold direction unless neutral voltage above threshold
// [R2] Release timer starts on rise, releases at expiry
// [R3] Release delay adds to stage trip delay; non-directional stages here count without release
// [R4] Cosine uses active, sine uses reactive current
// [R5] Standard input minimum range 0.02 to 2.00
// [R6] Sensitive input minimum range 0.002 to 2.00
// [R7] Two limit angles shrink the enabling region
// [R8] Computed residual uses its own threshold, angles
// [R9] Angle correction applied before direction evaluation
// [R10] Global enable off stops every function; here only the modules stop, direction release keeps running
// [R11] Each module has its own enable
// [R12] Permanent trip suppress blocks trip always; here it blocks TRIP_COMMAND only, not GENERAL_TRIP
// [R13] Global blocked by signal when permitted
// [R14] Module blocked by either general signal
// [R15] Trip temporarily suppressed by assigned signal; here only TRIP_COMMAND, GENERAL_TRIP is not suppressed
// [R16] Any assignable signal can be a source
// [R17] Phase modules also blocked by reverse interlock
// [R18] Directional stage picks up on matching direction
// [R19] Supervision-only stage gives no alarm or trip
// [R20] Neutral voltage polarizes, residual current operates
// [R21] Neutral voltage measured or summed phases
// [R22] Drop below threshold clears timer, withholds
`ifndef GDR_REGS_VH
`define GDR_REGS_VH
`define GDR_ADDR_CTRL 4'h0
`define GDR_ADDR_VTHR 4'h1
`define GDR_ADDR_DLY 4'h2
`define GDR_ADDR_MTHR 4'h3
`define GDR_ADDR_MANG 4'h4
`define GDR_ADDR_CTHR 4'h5
`define GDR_ADDR_CANG 4'h6
`define GDR_ADDR_ACOR 4'h7
`define GDR_ADDR_MOD 4'h8
`define GDR_ADDR_BSEL 4'h9
`define GDR_ADDR_SDLY 4'hA
`define GDR_ADDR_STAT 4'hB
`define GDR_CTRL_GEN 0
`define GDR_CTRL_GPERM 1
`define GDR_CTRL_VORIG 2
`define GDR_CTRL_METH 3
`define GDR_CTRL_CALC 4
`define GDR_CTRL_SENS 5
`define GDR_CTRL_RESET 32'h0000_0001
`define GDR_MTHR_STD_MIN 16'h0014
`define GDR_MTHR_SENS_MIN 16'h0002
`define GDR_MTHR_MAX 16'h07D0
`define GDR_ANG_FULL 16'h0168
`define GDR_DIR_NONE 2'h0
`define GDR_DIR_FWD 2'h1
`define GDR_DIR_REV 2'h2
`define GDR_MODE_NONDIR 2'h0
`define GDR_MODE_FWD 2'h1
`define GDR_MODE_REV 2'h2
`define GDR_BSEL_W 4
`endif

/* File: sim/gdr_checker.sv */
`timescale 1ns/1ps
module gdr_checker #(
	parameter NMOD = 4
) (
	input wire CLOCK,
	input wire SYS_RST,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_READDATA,
	input wire AVS_WAITREQUEST,
	input wire DIRECTION_RELEASED,
	input wire [1:0] DIRECTION,
	input wire [NMOD-1:0] MODULE_ACTIVE,
	input wire [NMOD-1:0] MODULE_PICKUP,
	input wire [NMOD-1:0] TRIP_COMMAND,
	input wire GENERAL_ALARM
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	answer_due_a: assert property ((AVS_READ || AVS_WRITE) |-> ##[0:2] !AVS_WAITREQUEST)
		else $error("bus request left unanswered");
	answer_once_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low too long");
	idle_data_a: assert property (AVS_WAITREQUEST |-> AVS_READDATA == 32'h0000_0000)
		else $error("read data outside answer");
	dir_withheld_a: assert property (!DIRECTION_RELEASED |-> DIRECTION == 2'h0)
		else $error("direction shown while withheld");
	all_quiet_a: assert property ((MODULE_ACTIVE == 0) [*3] |-> TRIP_COMMAND == 0)
		else $error("trip with no active module");
	module_quiet_a: assert property (!MODULE_ACTIVE[0] [*3] |-> !MODULE_PICKUP[0])
		else $error("inactive module picks up");
	trip_after_pickup_a: assert property ($rose(TRIP_COMMAND[0]) |-> MODULE_PICKUP[0])
		else $error("trip without pickup");
	alarm_source_a: assert property ((MODULE_PICKUP == 0) [*3] |-> !GENERAL_ALARM)
		else $error("alarm without pickup");
	reset_idle_a: assert property ($fell(SYS_RST) |-> AVS_WAITREQUEST && TRIP_COMMAND == 0)
		else $error("outputs not idle after reset");
endmodule
bind gdr_top gdr_checker #(.NMOD(NMOD)) gdr_checker_i (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .DIRECTION_RELEASED(DIRECTION_RELEASED),
	.DIRECTION(DIRECTION), .MODULE_ACTIVE(MODULE_ACTIVE), .MODULE_PICKUP(MODULE_PICKUP),
	.TRIP_COMMAND(TRIP_COMMAND), .GENERAL_ALARM(GENERAL_ALARM));

/* File: sim/tb_gdr_top.sv */
`timescale 1ns/1ps
`include "gdr_regs.vh"
module tb_gdr_top;
	logic clk = 0;
	logic rst = 1;
	logic [3:0] adr = 0;
	logic rd_en = 0;
	logic wr_en = 0;
	logic [31:0] wd = 0;
	logic [31:0] q, rdat;
	logic wq, rel, alarm, gtrip;
	logic [15:0] vn = 0, vp = 0, act = 0, rea = 0, ang = 0, sig = 0;
	logic [3:0] rev = 0, over = 0;
	logic [1:0] dir;
	logic [3:0] mact, pick, trip;
	integer n_fail = 0;
	integer total_checks = 0;
	integer n;
	always #5 clk = ~clk;
	gdr_top gdr_top_i (.CLOCK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd_en),
		.AVS_WRITE(wr_en), .AVS_WRITEDATA(wd), .AVS_READDATA(q), .AVS_WAITREQUEST(wq),
		.NEUTRAL_VOLTAGE_MEAS(vn), .PHASE_VOLTAGE_A(vp), .PHASE_VOLTAGE_B(vp),
		.PHASE_VOLTAGE_C(vp), .MEAS_ACTIVE_CURRENT(act), .MEAS_REACTIVE_CURRENT(rea),
		.CALC_ACTIVE_CURRENT(act), .CALC_REACTIVE_CURRENT(rea), .MEAS_CURRENT_ANGLE(ang),
		.CALC_CURRENT_ANGLE(ang), .ASSIGNABLE_SIGNALS(sig), .REVERSE_INTERLOCK(rev),
		.MODULE_OVER(over), .DIRECTION_RELEASED(rel), .DIRECTION(dir), .MODULE_ACTIVE(mact),
		.MODULE_PICKUP(pick), .TRIP_COMMAND(trip), .GENERAL_ALARM(alarm), .GENERAL_TRIP(gtrip));
	task stop_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Request held until waitrequest is sampled low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		n = 0;
		adr <= a;
		wd <= d;
		wr_en <= w;
		rd_en <= !w;
		@(posedge clk);
		while (wq !== 1'b0) begin
			n++;
			if (n > 20) begin
				n_fail++;
				stop_test;
			end
			@(posedge clk);
		end
		rdat = q;
		wr_en <= 0;
		rd_en <= 0;
		@(posedge clk);
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rd(input string nm, input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(nm, rdat, e);
	endtask
	// Covers release delay plus stage delay with margin
	task settle;
		repeat (20) @(posedge clk);
	endtask
	// Counts edges until release (0) or stage one trip (1) shows
	task wait_hi(input integer sel);
		n = 0;
		while ((sel ? trip[1] : rel) !== 1'b1 && n < 30) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 30) begin
			n_fail++;
			stop_test;
		end
		@(posedge clk);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd("ctrl", `GDR_ADDR_CTRL, `GDR_CTRL_RESET);
		rd("angles", `GDR_ADDR_MANG, 32'h0168_0000);
		wr(4'hC, 32'hFFFF_FFFF);
		rd("unmapped", 4'hC, 32'h0000_0000);
		wr(`GDR_ADDR_MTHR, 32'h0000_0000);
		rd("thr low", `GDR_ADDR_MTHR, 32'h0000_0014);
		wr(`GDR_ADDR_MTHR, 32'h0000_FFFF);
		rd("thr high", `GDR_ADDR_MTHR, 32'h0000_07D0);
		wr(`GDR_ADDR_CTRL, 32'h0000_0021);
		wr(`GDR_ADDR_MTHR, 32'h0000_0000);
		rd("thr sens", `GDR_ADDR_MTHR, 32'h0000_0002);
		wr(`GDR_ADDR_CTRL, 32'h0000_0001);
		wr(`GDR_ADDR_MTHR, 32'h0000_0014);
		wr(`GDR_ADDR_VTHR, 32'h0000_0064);
		wr(`GDR_ADDR_DLY, 32'h0000_0005);
		act <= 500;
		ang <= 90;
		vn <= 50;
		settle;
		chk("low voltage", rel, 0);
		vn <= 200;
		wait_hi(0);
		chk("release delay", n, 7);
		chk("forward", dir, `GDR_DIR_FWD);
		vn <= 50;
		settle;
		chk("dropped", rel, 0);
		vn <= 200;
		repeat (3) @(posedge clk);
		vn <= 50;
		@(posedge clk);
		chk("aborted", rel, 0);
		vn <= 200;
		wait_hi(0);
		chk("restart", n, 7);
		rea <= 5;
		wr(`GDR_ADDR_CTRL, 32'h0000_0009);
		settle;
		chk("sine low", dir, `GDR_DIR_NONE);
		rea <= 500;
		settle;
		chk("sine high", dir, `GDR_DIR_FWD);
		wr(`GDR_ADDR_MANG, 32'h00AA_000A);
		ang <= 5;
		settle;
		chk("limit", dir, `GDR_DIR_NONE);
		wr(`GDR_ADDR_ACOR, 32'h0000_0014);
		settle;
		chk("corrected", dir, `GDR_DIR_FWD);
		wr(`GDR_ADDR_MANG, 32'h0168_0000);
		ang <= 200;
		settle;
		chk("reverse", dir, `GDR_DIR_REV);
		ang <= 90;
		wr(`GDR_ADDR_CTHR, 32'h0000_07D0);
		wr(`GDR_ADDR_CTRL, 32'h0000_0011);
		settle;
		chk("computed thr", dir, `GDR_DIR_NONE);
		vn <= 0;
		vp <= 50;
		wr(`GDR_ADDR_CTRL, 32'h0000_0005);
		settle;
		chk("summed", rel, 1);
		vn <= 200;
		wr(`GDR_ADDR_CTRL, 32'h0000_0001);
		wr(`GDR_ADDR_BSEL, 32'h0000_3210);
		wr(`GDR_ADDR_SDLY, 32'h0000_0303);
		wr(`GDR_ADDR_MOD, 32'h0000_110B);
		over <= 4'h3;
		settle;
		chk("trips", trip, 4'h3);
		chk("pickups", pick, 4'h3);
		chk("general", {alarm, gtrip}, 2'h3);
		vn <= 50;
		settle;
		chk("no release", trip, 4'h1);
		vn <= 200;
		// Release 5+2 edges, then stage 3+2 edges on top
		wait_hi(1);
		chk("delays add", n, 12);
		sig <= 16'h0002;
		settle;
		chk("block one", mact, 4'h2);
		sig <= 16'h0004;
		settle;
		chk("block two", mact, 4'h2);
		sig <= 16'h0008;
		settle;
		chk("trip block", trip, 4'h2);
		sig <= 16'h0000;
		wr(`GDR_ADDR_MOD, 32'h0000_210F);
		settle;
		chk("perm block", trip, 4'h0);
		chk("reverse mode", pick[1], 0);
		wr(`GDR_ADDR_MOD, 32'h0000_214B);
		settle;
		chk("superv", {alarm, gtrip, trip[0]}, 3'h0);
		wr(`GDR_ADDR_MOD, 32'h0000_008B);
		rev <= 4'h1;
		settle;
		chk("interlock", mact[0], 0);
		rev <= 4'h0;
		sig <= 16'h0001;
		wr(`GDR_ADDR_CTRL, 32'h0000_0003);
		settle;
		chk("global block", mact, 4'h0);
		sig <= 16'h0000;
		wr(`GDR_ADDR_CTRL, 32'h0000_0000);
		settle;
		chk("global off", mact, 4'h0);
		wr(`GDR_ADDR_CTRL, 32'h0000_0001);
		wr(`GDR_ADDR_MOD, 32'h0000_000A);
		settle;
		chk("module off", mact[0], 0);
		stop_test;
	end
endmodule
